// ===== i2cd_regs.svh
`ifndef I2CD_REGS_SVH
`define I2CD_REGS_SVH

// Fixed upper part of the seven-bit slave address
`define I2CD_ADDR_PREFIX      5'h03
// Low address bits per strap level
`define I2CD_ID_STRAP_GND     2'h3
`define I2CD_ID_STRAP_VDD     2'h0
`define I2CD_ID_STRAP_OPEN    2'h2
// Strap sense codes on the addr_strap input
`define I2CD_STRAP_GND        2'h0
`define I2CD_STRAP_VDD        2'h1
// Field layout of the 16-bit input word
`define I2CD_WORD_TOP_BIT     15
`define I2CD_PD_HI_BIT        13
`define I2CD_PD_LO_BIT        12
`define I2CD_CODE_MSB         11
// Reset value of the input word, zero code and normal mode
`define I2CD_WORD_RESET       16'h0000
// Bits per byte and index of the last data byte of a write
`define I2CD_BYTE_BITS        4'h8
`define I2CD_LAST_BYTE        2'h1

`endif

// ===== i2cd_pkg.sv
package i2cd_pkg;

  // Protocol engine states
  typedef enum logic [3:0] {
    I2CD_IDLE, I2CD_ADDR, I2CD_ADDR_ACK, I2CD_WR, I2CD_WR_ACK,
    I2CD_RD, I2CD_RD_ACK, I2CD_IGNORE, I2CD_LOCKED
  } i2cd_state_e;

  // Line conditioner state
  typedef struct packed {
    logic [2:0] scl_ff;
    logic [2:0] sda_ff;
    logic       scl_f;
    logic       sda_f;
  } i2cd_sync_s;

  // Protocol engine state
  typedef struct packed {
    i2cd_state_e st;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  cnt;
    logic [1:0]  nbytes;
    logic        rw;
    logic [15:0] sh;
    logic [15:0] rb;
    logic [15:0] word;
    logic [11:0] code;
    logic        pd_hi;
    logic        pd_lo;
    logic        oe;
    logic        drv;
    logic [1:0]  id;
    logic        id_done;
  } i2cd_core_s;

endpackage

// ===== i2cd_line_if.sv
interface i2cd_line_if;
  logic scl;
  logic sda;
  modport src (output scl, output sda);
  modport dst (input scl, input sda);
endinterface

// ===== i2cd_sync.sv
module i2cd_sync
  import i2cd_pkg::*;
(
  // Clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst,
  // Raw bus lines
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  // Conditioned lines
  i2cd_line_if.src    line
);
  import i2cd_pkg::*;

  i2cd_sync_s s_r;
  i2cd_sync_s s_nxt;

  // Three stages per line; level moves once the last two agree
  always_comb begin
    s_nxt        = s_r;
    s_nxt.scl_ff = {s_r.scl_ff[1:0], scl_i};
    s_nxt.sda_ff = {s_r.sda_ff[1:0], sda_i};
    if (s_r.scl_ff[1] == s_r.scl_ff[2]) begin
      s_nxt.scl_f = s_r.scl_ff[2];
    end
    if (s_r.sda_ff[1] == s_r.sda_ff[2]) begin
      s_nxt.sda_f = s_r.sda_ff[2];
    end
  end

  // Idle bus is high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '{scl_ff: 3'h7, sda_ff: 3'h7, scl_f: 1'b1, sda_f: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign line.scl = s_r.scl_f;
  assign line.sda = s_r.sda_f;

endmodule // i2cd_sync

// ===== i2cd_slave.sv
`include "i2cd_regs.svh"

module i2cd_slave
  import i2cd_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Address strap sense
  input  wire logic [1:0]  addr_strap,
  // DAC side
  output logic [15:0]      dac_input_word,
  output logic [11:0]      dac_code,
  output logic             powerdown_select_hi,
  output logic             powerdown_select_lo
);
  import i2cd_pkg::*;

  i2cd_line_if line ();
  i2cd_core_s  c_r;
  i2cd_core_s  c_nxt;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic [6:0]  own_addr;

  // Strap level to low address bits
  function automatic logic [1:0] strap_id(input logic [1:0] lvl);
    unique case (lvl)
      `I2CD_STRAP_GND: strap_id = `I2CD_ID_STRAP_GND;
      `I2CD_STRAP_VDD: strap_id = `I2CD_ID_STRAP_VDD;
      default:         strap_id = `I2CD_ID_STRAP_OPEN;
    endcase
  endfunction

  // Line conditioner
  i2cd_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .line    (line.src)
  );

  // Bus events from conditioned lines
  assign scl_rise = line.scl & ~c_r.scl_q;
  assign scl_fall = ~line.scl & c_r.scl_q;
  assign start_ev = line.scl & c_r.scl_q & c_r.sda_q & ~line.sda;
  assign stop_ev  = line.scl & c_r.scl_q & ~c_r.sda_q & line.sda;
  assign own_addr = {`I2CD_ADDR_PREFIX, c_r.id};

  // Protocol engine
  always_comb begin
    c_nxt       = c_r;
    c_nxt.scl_q = line.scl;
    c_nxt.sda_q = line.sda;
    c_nxt.drv   = 1'b0;
    if (!c_r.id_done) begin
      c_nxt.id      = strap_id(addr_strap);
      c_nxt.id_done = 1'b1;
    end
    if (c_r.st == I2CD_LOCKED) begin
      c_nxt.oe = 1'b0;
    end else if (start_ev) begin
      // Start or repeated start; any unfinished word is dropped
      c_nxt.st     = I2CD_ADDR;
      c_nxt.cnt    = 4'h0;
      c_nxt.nbytes = 2'h0;
      c_nxt.oe     = 1'b0;
    end else if (stop_ev) begin
      c_nxt.oe = 1'b0;
      // A stop after seven bits needs a clock high, which counts as the eighth rise
      if (c_r.st == I2CD_ADDR && c_r.cnt == `I2CD_BYTE_BITS) begin
        c_nxt.st = I2CD_LOCKED;
      end else begin
        c_nxt.st = I2CD_IDLE;
      end
    end else begin
      unique case (c_r.st)
        I2CD_IDLE, I2CD_IGNORE: begin
          c_nxt.oe = 1'b0;
        end
        I2CD_ADDR: begin
          if (scl_rise) begin
            c_nxt.sh  = {c_r.sh[14:0], line.sda};
            c_nxt.cnt = c_r.cnt + 4'h1;
          end else if (scl_fall && c_r.cnt == `I2CD_BYTE_BITS) begin
            c_nxt.rw = c_r.sh[0];
            if (c_r.sh[7:1] == own_addr) begin
              c_nxt.st = I2CD_ADDR_ACK;
              c_nxt.oe = 1'b1;
            end else begin
              c_nxt.st = I2CD_IGNORE;
            end
          end
        end
        I2CD_ADDR_ACK: begin
          if (scl_fall) begin
            c_nxt.cnt = 4'h0;
            if (c_r.rw) begin
              // Load readback and clear it for the next read
              c_nxt.st = I2CD_RD;
              c_nxt.sh = c_r.rb;
              c_nxt.rb = `I2CD_WORD_RESET;
              c_nxt.oe = ~c_r.rb[`I2CD_WORD_TOP_BIT];
            end else begin
              c_nxt.st = I2CD_WR;
              c_nxt.oe = 1'b0;
            end
          end
        end
        I2CD_WR: begin
          if (scl_rise) begin
            c_nxt.sh  = {c_r.sh[14:0], line.sda};
            c_nxt.cnt = c_r.cnt + 4'h1;
          end else if (scl_fall && c_r.cnt == `I2CD_BYTE_BITS) begin
            if (c_r.nbytes <= `I2CD_LAST_BYTE) begin
              c_nxt.st = I2CD_WR_ACK;
              c_nxt.oe = 1'b1;
            end else begin
              c_nxt.st = I2CD_IGNORE;
            end
          end
        end
        I2CD_WR_ACK: begin
          if (scl_fall) begin
            c_nxt.oe     = 1'b0;
            c_nxt.cnt    = 4'h0;
            c_nxt.nbytes = c_r.nbytes + 2'h1;
            c_nxt.st     = I2CD_WR;
            if (c_r.nbytes == `I2CD_LAST_BYTE) begin
              // Commit the whole word only now
              c_nxt.word  = c_r.sh;
              c_nxt.rb    = c_r.sh;
              c_nxt.code  = c_r.sh[`I2CD_CODE_MSB:0];
              c_nxt.pd_hi = c_r.sh[`I2CD_PD_HI_BIT];
              c_nxt.pd_lo = c_r.sh[`I2CD_PD_LO_BIT];
            end
          end
        end
        I2CD_RD: begin
          if (scl_fall) begin
            c_nxt.cnt = c_r.cnt + 4'h1;
            c_nxt.sh  = {c_r.sh[14:0], 1'b0};
            if (c_r.cnt == `I2CD_BYTE_BITS - 4'h1) begin
              c_nxt.st = I2CD_RD_ACK;
              c_nxt.oe = 1'b0;
            end else begin
              c_nxt.oe = ~c_r.sh[`I2CD_WORD_TOP_BIT - 1];
            end
          end
        end
        I2CD_RD_ACK: begin
          if (scl_rise) begin
            // Master not-acknowledge or second byte done ends the read
            if (line.sda || c_r.nbytes == `I2CD_LAST_BYTE) begin
              c_nxt.st = I2CD_IGNORE;
            end else begin
              c_nxt.nbytes = `I2CD_LAST_BYTE;
            end
          end else if (scl_fall) begin
            c_nxt.st  = I2CD_RD;
            c_nxt.cnt = 4'h0;
            c_nxt.oe  = ~c_r.sh[`I2CD_WORD_TOP_BIT];
          end
        end
        I2CD_LOCKED: begin
          c_nxt.oe = 1'b0;
        end
      endcase
    end
  end

  // State register; the strap is taken on the first cycle after release
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c_r <= '{st: I2CD_IDLE, scl_q: 1'b1, sda_q: 1'b1, cnt: 4'h0, nbytes: 2'h0,
               rw: 1'b0, sh: 16'h0000, rb: `I2CD_WORD_RESET,
               word: `I2CD_WORD_RESET, code: 12'h000, pd_hi: 1'b0, pd_lo: 1'b0,
               oe: 1'b0, drv: 1'b0, id: 2'h0, id_done: 1'b0};
    end else begin
      c_r <= c_nxt;
    end
  end

  // Outputs straight from the state register
  assign sda_o               = c_r.drv;
  assign sda_oe              = c_r.oe;
  assign dac_input_word      = c_r.word;
  assign dac_code            = c_r.code;
  assign powerdown_select_hi = c_r.pd_hi;
  assign powerdown_select_lo = c_r.pd_lo;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_addr_done;
    c_r.st == I2CD_ADDR && scl_fall && c_r.cnt == `I2CD_BYTE_BITS;
  endsequence
  sequence s_own_match;
    s_addr_done ##0 (c_r.sh[7:1] == own_addr && !start_ev && !stop_ev);
  endsequence
  sequence s_foreign;
    s_addr_done ##0 (c_r.sh[7:1] != own_addr && !start_ev && !stop_ev);
  endsequence
  sequence s_commit;
    c_r.st == I2CD_WR_ACK && scl_fall && c_r.nbytes == `I2CD_LAST_BYTE && !start_ev
      && !stop_ev;
  endsequence

  a_ack_own_addr: assert property (s_own_match |=> sda_oe && c_r.st == I2CD_ADDR_ACK)
    else $error("own address not acknowledged");
  a_foreign_quiet: assert property (s_foreign |=> !sda_oe [*2])
    else $error("foreign address drove the line");
  a_ack_only_own: assert property ($rose(sda_oe) && $past(c_r.st) == I2CD_ADDR |->
      $past(c_r.sh[7:1]) == own_addr)
    else $error("acknowledged a foreign address");
  a_drive_scl_low: assert property ($rose(sda_oe) |-> $past(scl_fall))
    else $error("drive began outside clock low");
  a_commit_word: assert property (s_commit |=> dac_input_word == $past(c_r.sh)
      && dac_code == $past(c_r.sh[11:0]))
    else $error("word not committed after second ack");
  a_word_cause: assert property ($changed(dac_input_word) |->
      $past(c_r.st) == I2CD_WR_ACK && $past(c_r.nbytes) == `I2CD_LAST_BYTE)
    else $error("word changed without full write");
  a_mode_field: assert property ($changed(powerdown_select_hi) |->
      $past(c_r.st) == I2CD_WR_ACK)
    else $error("mode changed outside commit");
  a_read_clears: assert property (c_r.st == I2CD_ADDR_ACK && c_r.rw && scl_fall
      && !start_ev && !stop_ev |=> c_r.rb == 16'h0000 ##0 c_r.st == I2CD_RD)
    else $error("readback not cleared");
  a_lock_entry: assert property (stop_ev && !start_ev && c_r.st == I2CD_ADDR
      && c_r.cnt == `I2CD_BYTE_BITS |=> c_r.st == I2CD_LOCKED)
    else $error("stop inside address byte did not lock");
  a_lock_hold: assert property (c_r.st == I2CD_LOCKED |=>
      c_r.st == I2CD_LOCKED && !sda_oe)
    else $error("locked state left");
  a_start_addr: assert property (start_ev && c_r.st != I2CD_LOCKED |=>
      c_r.st == I2CD_ADDR && c_r.cnt == 4'h0)
    else $error("start did not open address phase");
  a_strap_map: assert property ($rose(c_r.id_done) |->
      c_r.id == strap_id($past(addr_strap)))
    else $error("strap decode wrong");

endmodule // i2cd_slave

// ===== i2cd_master_model.sv
module i2cd_master_model (
  // Clock
  input  wire logic ref_clk,
  // Bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idles released and high
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Wait n reference cycles, so all changes land just after an edge
  task automatic ph(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Data falls while clock high opens a transfer
  task automatic start();
    sda_pull <= 1'b0;
    ph(2);
    scl <= 1'b1;
    ph(4);
    sda_pull <= 1'b1;
    ph(4);
    scl <= 1'b0;
    ph(2);
  endtask

  // Data low then rises while clock high closes a transfer
  task automatic stop();
    sda_pull <= 1'b1;
    ph(2);
    scl <= 1'b1;
    ph(4);
    sda_pull <= 1'b0;
    ph(4);
  endtask

  // One 200 ns clock pulse: low six cycles, high two; data set early in the low phase
  // The long low phase lets the slave's synchronised drive settle before the rise
  task automatic bit_x(input logic b, output logic s);
    sda_pull <= ~b;
    ph(4);
    scl <= 1'b1;
    ph(2);
    s = sda;
    scl <= 1'b0;
    ph(2);
  endtask

  // Eight bits MSB first plus the acknowledge slot
  task automatic byte_x(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
  endtask
endmodule // i2cd_master_model

// ===== i2c_dac_input_port_tb_top.sv
module i2c_dac_input_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  addr_strap = 2'h0;
  logic        scl;
  logic        m_pull;
  logic        sda_o;
  logic        sda_oe;
  logic [15:0] word;
  logic [11:0] code;
  logic        pd_hi;
  logic        pd_lo;
  logic [6:0]  own;
  int          fails = 0;
  int          n_checks = 0;
  int          cycles = 0;
  // Open-drain wire with pull-up
  wire         sda = ~(m_pull | (sda_oe & ~sda_o));

  // 40 MHz reference clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  i2cd_slave dut (.ref_clk(ref_clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_strap(addr_strap), .dac_input_word(word), .dac_code(code),
    .powerdown_select_hi(pd_hi), .powerdown_select_lo(pd_lo));
  i2cd_master_model m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(m_pull));

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Reset with a strap level; own address follows from it
  task automatic do_reset(input logic [1:0] s, input logic [1:0] id);
    rst        <= 1'b1;
    addr_strap <= s;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    own = {5'h03, id};
  endtask

  task automatic xfer(input logic [7:0] tx, input logic m_ack, output logic [7:0] rx,
                      output logic s_ack);
    logic [8:0] r;
    m.byte_x({tx, ~m_ack}, r);
    rx    = r[8:1];
    s_ack = ~r[0];
  endtask

  // Write frame: address byte and two data bytes
  task automatic wr(input logic [7:0] a, input logic [15:0] w, input logic [2:0] exp);
    logic [7:0] rx;
    logic [2:0] ak;
    m.start();
    xfer(a, 1'b0, rx, ak[2]);
    xfer(w[15:8], 1'b0, rx, ak[1]);
    xfer(w[7:0], 1'b0, rx, ak[0]);
    m.stop();
    check("write acks", 16'(exp), 16'(ak));
  endtask

  task automatic chk_out(input logic [15:0] w);
    check("word", w, word);
    check("code", 16'(w[11:0]), 16'(code));
    check("mode", 16'(w[13:12]), 16'({pd_hi, pd_lo}));
  endtask

  task automatic t_strap();
    logic [1:0] ids [3] = '{2'h3, 2'h0, 2'h2};
    for (int i = 0; i < 3; i++) begin
      do_reset(2'(i), ids[i]);
      chk_out(16'h0000);
      check("idle drive", 16'h0000, 16'(sda_oe));
      wr({own, 1'b0}, 16'h0a50 + 16'(i), 3'b111);
      wr({5'h03, ~own[1:0], 1'b0}, 16'h0123, 3'b000);
      chk_out(16'h0a50 + 16'(i));
    end
  endtask

  task automatic t_refuse();
    logic [7:0] bad [4] = '{8'h00, 8'h08, 8'h0e, 8'hf0};
    for (int i = 0; i < 4; i++) begin
      wr(bad[i], 16'h0fff, 3'b000);
    end
    chk_out(16'h0a52);
  endtask

  task automatic t_modes();
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      w = {2'b00, 2'(i), 12'hfff - 12'(i * 12'h111)};
      wr({own, 1'b0}, w, 3'b111);
      chk_out(w);
    end
  endtask

  task automatic t_abort();
    logic [7:0] rx;
    logic       ak;
    m.start();
    xfer({own, 1'b0}, 1'b0, rx, ak);
    xfer(8'h01, 1'b0, rx, ak);
    m.stop();
    chk_out(16'h3ccc);
    m.start();
    xfer({own, 1'b0}, 1'b0, rx, ak);
    xfer(8'h02, 1'b0, rx, ak);
    xfer(8'h34, 1'b0, rx, ak);
    xfer(8'h56, 1'b0, rx, ak);
    m.stop();
    check("third ack", 16'h0000, 16'(ak));
    chk_out(16'h0234);
  endtask

  task automatic t_read(input logic [15:0] exp);
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ak;
    m.start();
    xfer({own, 1'b1}, 1'b0, hi, ak);
    check("read ack", 16'h0001, 16'(ak));
    xfer(8'hff, 1'b1, hi, ak);
    xfer(8'hff, 1'b0, lo, ak);
    m.stop();
    check("readback", exp, {hi, lo});
  endtask

  task automatic t_lock();
    logic b;
    m.start();
    for (int i = 6; i >= 0; i--) begin
      m.bit_x(own[i], b);
    end
    m.stop();
    wr({own, 1'b0}, 16'h0777, 3'b000);
    chk_out(16'h0234);
  endtask

  initial begin
    t_strap();
    t_refuse();
    t_modes();
    t_abort();
    t_read(16'h0234);
    t_read(16'h0000);
    t_lock();
    summarize();
  end
endmodule // i2c_dac_input_port_tb_top
